/* ecdpm_pkg.sv */
// Functional notes
// RL1: Each write computes eight check bits per 64-bit word, stored beside it.
// RL2: Each read corrects single-bit errors and detects double-bit errors.
// RL3: Two flags encode no error, single corrected, double detected.
// RL4: Single errors are corrected on output only; the array keeps the bad word.
// RL5: Correction exists only in simple dual-port form: one write, one read port.
// RL6: Hard variant tiles protected 512x64 primitives built from two 18k blocks.
// RL7: Spare bits stay covered, so double flag may fire for spare-only corruption.
// RL8: No byte enables, no output reset value, no init contents, equal widths.
// RL9: Ports run read-first, or no-change on the older family; nothing else.
// RL10: User logic may raise inject inputs with a write to corrupt that word.
// RL11: An error-address output gives the read address of each reported error.
// RL12: Without correction, inject inputs tie low and flags are not brought out.
// RL13: Both injects on one write: double wins, only double flag, data uncorrected.
// RL14: Family without injection behaves unprotected, both flags held low; here INJECT_ON gates only the injects, not the flags.
// RL15: Soft variant corrects singles, detects doubles, up to 64 data, 8 parity.
// RL16: Soft variant uses a Hamming code parameterised over data width.
// RL17: Soft variant accepts at most 64 data bits, simple dual-port only.
// RL18: Soft variant offers optional input and output register stages.
// RL19: Soft variant stays compatible with output pipeline and enable inputs.
// RL20: Check bits: 4 for 1-4, 5 for 5-11, 6 for 12-26, 7 for 27-57, else 8.
// RL21: Flags and error address are valid in the same cycle as their data.
// RL22: Single injection flips exactly one stored bit, double exactly two.
package ecdpm_pkg;
  // ==========================================================
  // Geometry
  localparam int DATA_W   = 64;
  localparam int CHECK_W  = (DATA_W <= 4) ? 4 : (DATA_W <= 11) ? 5 : (DATA_W <= 26) ? 6 :
                            (DATA_W <= 57) ? 7 : 8; // RL20
  localparam int HAM_W    = CHECK_W - 1;
  localparam int CODE_W   = DATA_W + HAM_W;
  localparam int WORD_W   = DATA_W + CHECK_W;
  localparam int ADDR_W   = 9;
  localparam int DEPTH    = 512;
  // ==========================================================
  // Injection positions inside the stored word, data and check bits alike.
  localparam int INJ_POS_A = 0;
  localparam int INJ_POS_B = DATA_W;
  // ==========================================================
  // Options
  localparam bit ECC_ON       = 1'b1;
  localparam bit INJECT_ON    = 1'b1;
  localparam bit IN_REG_ON    = 1'b0;
  localparam bit OUT_REG_ON   = 1'b0;
endpackage

/* ecdpm_ram.sv */
`timescale 1ns/1ps
// ==========================================================
// Simple dual-port array, registered read, read-first on collision.
module ecdpm_ram import ecdpm_pkg::*; (
  input  wire logic              clk_sys,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WORD_W-1:0] wr_word,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WORD_W-1:0] rd_word
);
  logic [WORD_W-1:0] mem [DEPTH];

  // No reset and no init contents: the array holds whatever was written.
  always_ff @(posedge clk_sys) begin // RL8
    if (wr_en) begin
      mem[wr_addr] <= wr_word;
    end
  end

  // Read returns the old word when a write hits the same address.
  always_ff @(posedge clk_sys) begin // RL9
    if (rd_en) begin
      rd_word <= mem[rd_addr];
    end
  end
endmodule // ecdpm_ram

/* ecdpm_top.sv */
// Our own choices: the address-and-strobe port.
`timescale 1ns/1ps
// ==========================================================
// Protected simple dual-port memory: one write port, one read port.
module ecdpm_top import ecdpm_pkg::*; ( // RL5 RL17
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              inject_single_error,
  input  wire logic              inject_double_error,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   single_error_flag,
  output logic                   double_error_flag,
  output logic      [ADDR_W-1:0] error_read_address
);

  // ==========================================================
  // Hamming helpers
  function automatic bit is_pow2(input int p);
    is_pow2 = (p & (p - 1)) == 0;
  endfunction

  // Place data bits at non-power-of-two positions of the code word.
  function automatic logic [CODE_W:1] spread(input logic [DATA_W-1:0] d);
    int k;
    spread = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if (!is_pow2(p)) begin
        spread[p] = d[k];
        k++;
      end
    end
  endfunction

  function automatic logic [DATA_W-1:0] gather(input logic [CODE_W:1] c);
    int k;
    gather = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if (!is_pow2(p)) begin
        gather[k] = c[p];
        k++;
      end
    end
  endfunction

  // Syndrome over all positions; on a fresh spread it yields the check bits.
  function automatic logic [HAM_W-1:0] syndrome(input logic [CODE_W:1] c);
    syndrome = '0;
    for (int p = 1; p <= CODE_W; p++) begin
      if (c[p]) begin
        syndrome = syndrome ^ HAM_W'(p);
      end
    end
  endfunction

  // ==========================================================
  // Optional input stage.
  logic              w_en;
  logic [ADDR_W-1:0] w_addr;
  logic [DATA_W-1:0] w_data;
  logic              w_inj_s;
  logic              w_inj_d;

  generate
    if (IN_REG_ON) begin : g_in_reg
      always_ff @(posedge clk_sys or negedge rst_b) begin // RL18
        if (!rst_b) begin
          w_en    <= 1'b0;
          w_addr  <= '0;
          w_data  <= '0;
          w_inj_s <= 1'b0;
          w_inj_d <= 1'b0;
        end else begin
          w_en    <= wr_en;
          w_addr  <= wr_addr;
          w_data  <= wr_data;
          w_inj_s <= inject_single_error;
          w_inj_d <= inject_double_error;
        end
      end
    end else begin : g_in_wire
      always_comb begin
        w_en    = wr_en;
        w_addr  = wr_addr;
        w_data  = wr_data;
        w_inj_s = inject_single_error;
        w_inj_d = inject_double_error;
      end
    end
  endgenerate

  // ==========================================================
  // Encoder: Hamming bits plus overall parity, stored with the data.
  logic [CODE_W:1]   enc_spread;
  logic [HAM_W-1:0]  enc_ham;
  logic              enc_par;
  logic [WORD_W-1:0] enc_word;
  logic [WORD_W-1:0] inj_mask;
  logic              inj_s_live;
  logic              inj_d_live;

  always_comb begin
    enc_spread = spread(w_data);
    enc_ham    = syndrome(enc_spread); // RL1 RL16
    enc_par    = ^{w_data, enc_ham};
    enc_word   = {enc_par, enc_ham, w_data}; // RL1
  end

  // Injection is gated off when correction or injection is not built.
  always_comb begin
    inj_s_live = ECC_ON && INJECT_ON && w_inj_s; // RL12 RL14
    inj_d_live = ECC_ON && INJECT_ON && w_inj_d; // RL12
    inj_mask   = '0;
    if (inj_d_live) begin // RL13
      inj_mask[INJ_POS_A] = 1'b1;
      inj_mask[INJ_POS_B] = 1'b1; // RL22
    end else if (inj_s_live) begin
      inj_mask[INJ_POS_A] = 1'b1; // RL22 RL10
    end
  end

  // ==========================================================
  // Array.
  logic [WORD_W-1:0] ram_q;

  ecdpm_ram u_ram (
    .clk_sys (clk_sys),
    .wr_en   (w_en),
    .wr_addr (w_addr),
    .wr_word (enc_word ^ inj_mask),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_word (ram_q)
  ); // RL6

  // Address follows the data through the array latency.
  logic [ADDR_W-1:0] rd_addr_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin // RL21
    if (!rst_b) begin
      rd_addr_q <= '0;
    end else if (rd_en) begin
      rd_addr_q <= rd_addr;
    end
  end

  logic rd_valid_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
    end
  end

  // ==========================================================
  // Decoder: the whole stored word is checked, spare bits included.
  logic [DATA_W-1:0] dec_data;
  logic [HAM_W-1:0]  dec_ham;
  logic              dec_par;
  logic [CODE_W:1]   dec_code;
  logic [HAM_W-1:0]  dec_syn;
  logic              dec_par_bad;
  logic              dec_single;
  logic              dec_double;
  logic [DATA_W-1:0] dec_fixed;

  always_comb begin
    dec_data = ram_q[DATA_W-1:0];
    dec_ham  = ram_q[DATA_W +: HAM_W];
    dec_par  = ram_q[WORD_W-1];
    dec_code = spread(dec_data);
    for (int i = 0; i < HAM_W; i++) begin
      dec_code[1 << i] = dec_ham[i];
    end
    dec_syn     = syndrome(dec_code); // RL2 RL15
    dec_par_bad = ^ram_q;
    dec_single  = ECC_ON && dec_par_bad; // RL3
    dec_double  = ECC_ON && !dec_par_bad && (dec_syn != '0); // RL3 RL7
    if (dec_single && dec_syn != '0 && int'(dec_syn) <= CODE_W) begin
      dec_code[dec_syn] = ~dec_code[dec_syn]; // RL2
    end
    // Double errors leave the data as read, no correction.
    dec_fixed = dec_double ? dec_data : gather(dec_code); // RL13
  end

  // ==========================================================
  // Output stage: the array output register is the latency; an optional
  // extra register adds one more cycle to data, flags and address alike.
  logic [DATA_W-1:0] o_data;
  logic              o_single;
  logic              o_double;
  logic [ADDR_W-1:0] o_addr;
  logic              o_valid;

  generate
    if (OUT_REG_ON) begin : g_out_reg
      always_ff @(posedge clk_sys or negedge rst_b) begin // RL18 RL19
        if (!rst_b) begin
          o_data   <= '0;
          o_single <= 1'b0;
          o_double <= 1'b0;
          o_addr   <= '0;
          o_valid  <= 1'b0;
        end else begin
          o_data   <= dec_fixed;
          o_single <= dec_single && rd_valid_q;
          o_double <= dec_double && rd_valid_q;
          o_addr   <= rd_addr_q;
          o_valid  <= rd_valid_q;
        end
      end
    end else begin : g_out_wire
      always_comb begin
        o_data   = dec_fixed;
        o_single = dec_single && rd_valid_q;
        o_double = dec_double && rd_valid_q;
        o_addr   = rd_addr_q;
        o_valid  = rd_valid_q;
      end
    end
  endgenerate

  // Corrected data go out; the array word stays untouched.
  assign rd_data            = o_data; // RL4
  assign single_error_flag  = o_valid && o_single; // RL3 RL21
  assign double_error_flag  = o_valid && o_double; // RL3 RL21
  assign error_read_address = o_addr; // RL11

endmodule // ecdpm_top

/* ecdpm_checker_asserts.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checker with a shadow of every written word and its injection kind.
module ecdpm_checker import ecdpm_pkg::*; (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              inject_single_error,
  input wire logic              inject_double_error,
  input wire logic              rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              single_error_flag,
  input wire logic              double_error_flag,
  input wire logic [ADDR_W-1:0] error_read_address
);
  logic [DATA_W-1:0] shadow [DEPTH];
  logic [1:0]        kind   [DEPTH];
  logic [DATA_W-1:0] exp_q;
  logic [1:0]        kind_q;
  // Shadow follows writes; double injection outranks single.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      shadow[wr_addr] <= wr_data;
      kind[wr_addr]   <= inject_double_error ? 2'h2 : {1'b0, inject_single_error};
    end
  end
  // Sampled on the read edge, so a colliding write is never seen here.
  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      exp_q  <= shadow[rd_addr];
      kind_q <= kind[rd_addr];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  flags_idle_a: assert property (!$past(rd_en) |-> !single_error_flag && !double_error_flag) else $error("flag without read");
  flags_excl_a: assert property (!(single_error_flag && double_error_flag)) else $error("both flags high");
  err_addr_a: assert property (rd_en |=> error_read_address == $past(rd_addr)) else $error("bad error address");
  addr_hold_a: assert property (!rd_en |=> $stable(error_read_address)) else $error("address moved");
  data_hold_a: assert property ($past(rd_en) && !rd_en |=> $stable(rd_data)) else $error("data moved");
  clean_read_a: assert property (rd_en ##1 kind_q == 2'h0 |-> rd_data == exp_q && !single_error_flag
    && !double_error_flag) else $error("clean read wrong");
  single_fix_a: assert property (rd_en ##1 kind_q == 2'h1 |-> rd_data == exp_q && single_error_flag
    && !double_error_flag) else $error("single not fixed");
  double_det_a: assert property (rd_en ##1 kind_q == 2'h2 |-> rd_data == (exp_q ^ (DATA_W'(1) << INJ_POS_A))
    && double_error_flag && !single_error_flag) else $error("double not flagged");
  cover property (rd_en ##1 single_error_flag);
  cover property (rd_en ##1 double_error_flag);
  cover property (rd_en && wr_en && rd_addr == wr_addr);
endmodule // ecdpm_checker

bind ecdpm_top ecdpm_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr),
  .wr_data(wr_data), .inject_single_error(inject_single_error), .inject_double_error(inject_double_error),
  .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .single_error_flag(single_error_flag),
  .double_error_flag(double_error_flag), .error_read_address(error_read_address));

/* ecdpm_user_model.sv */
`timescale 1ns/1ps
// ==========================================================
// User fabric on both ports; each task drives right after an edge.
module ecdpm_user_model import ecdpm_pkg::*; (
  input wire logic         clk_sys,
  output logic              wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic              inject_single_error,
  output logic              inject_double_error,
  output logic              rd_en,
  output logic [ADDR_W-1:0] rd_addr
);
  // Quiet port at time zero.
  initial begin
    {wr_en, rd_en, inject_single_error, inject_double_error} = 4'h0;
    {wr_addr, wr_data, rd_addr} = '0;
  end
  // Write with optional injection, held to the taking edge; the read strobe drops so no stale read rides along.
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic s, input logic x);
    rd_en <= 1'b0;
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    inject_single_error <= s;
    inject_double_error <= x;
    @(posedge clk_sys);
  endtask
  // Read only: a write strobe left high here would keep rewriting the last word.
  task automatic get(input logic [ADDR_W-1:0] a);
    wr_en <= 1'b0;
    inject_single_error <= 1'b0;
    inject_double_error <= 1'b0;
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
  endtask
  // Write and read taken on the same edge, for collision tests.
  task automatic put_get(input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] d, input logic [ADDR_W-1:0] ra);
    wr_en <= 1'b1;
    wr_addr <= wa;
    wr_data <= d;
    {inject_single_error, inject_double_error} <= 2'h0;
    rd_en <= 1'b1;
    rd_addr <= ra;
    @(posedge clk_sys);
  endtask
  // Released lines flip so that stale values never pass for live ones.
  task automatic rest();
    {wr_en, rd_en, inject_single_error, inject_double_error} <= 4'h0;
    wr_addr <= ~wr_addr;
    wr_data <= ~wr_data;
    rd_addr <= ~rd_addr;
    @(posedge clk_sys);
  endtask
endmodule // ecdpm_user_model

/* ecdpm_top_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the protected memory.
module ecdpm_top_tb import ecdpm_pkg::*; ;
  logic              clk_sys = 1'b0;
  logic              rst_b = 1'b0;
  logic              wr_en, inject_single_error, inject_double_error, rd_en;
  logic [ADDR_W-1:0] wr_addr, rd_addr, error_read_address;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic              single_error_flag, double_error_flag;
  int                n_mismatch = 0;
  int                checked = 0;
  localparam logic [DATA_W-1:0] DA = 64'hA5A5_0F0F_1234_5678;
  localparam logic [DATA_W-1:0] DB = 64'hFFFF_0000_C3C3_9E01;
  // Clock, 8 ns period.
  always #4 clk_sys = ~clk_sys;
  ecdpm_user_model u_user (.clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .inject_single_error(inject_single_error), .inject_double_error(inject_double_error),
    .rd_en(rd_en), .rd_addr(rd_addr));
  ecdpm_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .inject_single_error(inject_single_error), .inject_double_error(inject_double_error), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .single_error_flag(single_error_flag),
    .double_error_flag(double_error_flag), .error_read_address(error_read_address));
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Read one word; the answer stands only in the next cycle, so look 1 ns in.
  // One edge then passes so that the next request is again driven on an edge.
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] f);
    u_user.get(a);
    #1;
    check(rd_data, d);
    check(DATA_W'({single_error_flag, double_error_flag}), DATA_W'(f));
    check(DATA_W'(error_read_address), DATA_W'(a));
    @(posedge clk_sys);
  endtask
  task automatic t_clean();
    u_user.put(9'h000, DA, 1'b0, 1'b0);
    u_user.put(9'h1FF, DB, 1'b0, 1'b0);
    rd_chk(9'h000, DA, 2'h0);
    rd_chk(9'h1FF, DB, 2'h0);
    $display("clean done");
  endtask
  // Single errors are fixed on output yet stay in the array until rewritten.
  task automatic t_single();
    u_user.put(9'h007, DA, 1'b1, 1'b0);
    rd_chk(9'h007, DA, 2'h2);
    rd_chk(9'h007, DA, 2'h2);
    u_user.put(9'h007, DA, 1'b0, 1'b0);
    rd_chk(9'h007, DA, 2'h0);
    $display("single done");
  endtask
  task automatic t_double();
    u_user.put(9'h008, DB, 1'b0, 1'b1);
    u_user.put(9'h009, DA, 1'b1, 1'b1);
    rd_chk(9'h008, DB ^ (DATA_W'(1) << INJ_POS_A), 2'h1);
    rd_chk(9'h009, DA ^ (DATA_W'(1) << INJ_POS_A), 2'h1);
    $display("double done");
  endtask
  // Write and read on the same edge must return the old word.
  task automatic t_collide();
    u_user.put(9'h00A, DA, 1'b0, 1'b0);
    u_user.put_get(9'h00A, DB, 9'h00A);
    #1;
    check(rd_data, DA);
    @(posedge clk_sys);
    u_user.rest();
    #1;
    check(DATA_W'({single_error_flag, double_error_flag}), DATA_W'(0));
    @(posedge clk_sys);
    rd_chk(9'h00A, DB, 2'h0);
    $display("collide done");
  endtask
  // A reset in mid-run clears flags and address at once.
  task automatic t_reset();
    u_user.rest();
    rst_b <= 1'b0;
    #1;
    check(DATA_W'({single_error_flag, double_error_flag, error_read_address}), DATA_W'(0));
    @(posedge clk_sys);
    rst_b <= 1'b1;
    u_user.put(9'h0C3, DB, 1'b1, 1'b0);
    rd_chk(9'h0C3, DB, 2'h2);
    $display("reset done");
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_clean();
    t_single();
    t_double();
    t_collide();
    t_reset();
    results();
  end
  // Watchdog: a hang counts as a mismatch.
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule // ecdpm_top_tb
